// ---- shared/sub_decode_map.svh ----
// Opcode patterns, field positions, register numbers and reset values for the subtract decoder
`ifndef SUB_DECODE_MAP_SVH
`define SUB_DECODE_MAP_SVH

// ==========================================================================
// Opcode patterns (first halfword unless noted)
`define OP16_SUB_REG      7'h0d
`define OP16_SUB_CONST_MID_BITS     7'h0f
`define OP16_SP_IMM       9'h161
`define OP32_PREFIX       5'h1e
`define OP32_REG          11'h75d
`define OP32_IMM_MID      5'h0d
`define OP32_IMMW_MID     6'h2a

// ==========================================================================
// Register numbers and limits
`define REG_SP            4'hd
`define REG_PC            4'hf
`define SP_SHIFT_MAX      6'h03
`define SIGN_BIT          31

// ==========================================================================
// Flag positions inside application_status_flags and reset value
`define FLAG_N            3
`define FLAG_Z            2
`define FLAG_C            1
`define FLAG_V            0
`define FLAGS_RESET       4'h0

`endif

// ---- shared/sub_decode_pkg.sv ----
// Types shared by the subtract decoder and its operand shifter
`default_nettype none

package sub_decode_pkg;

   // Which subtract variant the current word decodes to
   typedef enum logic [2:0] {
      OP_NONE,
      OP_REG_IMM,
      OP_REG_REG,
      OP_SP_IMM,
      OP_SP_REG
   } op_kind_type;

   // Barrel shifter operations
   typedef enum logic [2:0] {
      SH_LSL,
      SH_LSR,
      SH_ASR,
      SH_ROR,
      SH_RRX
   } shift_kind_type;

endpackage : sub_decode_pkg

`default_nettype wire

// ---- hw/operand_shifter.sv ----
// Barrel shifter that forms the shifted second operand
`default_nettype none

module operand_shifter
   import sub_decode_pkg::*;
(
   input  wire logic [31:0]   value,
   input  wire shift_kind_type kind,
   input  wire logic [5:0]    amount,
   input  wire logic          carry_in,
   output logic [31:0]        result
);

   logic [63:0] rotated;

   // ======================================================================
   // Shift network
   // Amount 32 is legal for the right shifts; SV fills correctly past width
   always_comb begin
      rotated = {value, value} >> amount[4:0];
      result  = value;
      unique case (kind)
         SH_LSL: result = value << amount;
         SH_LSR: result = value >> amount;
         SH_ASR: result = 32'($signed(value) >>> amount);
         SH_ROR: result = rotated[31:0];
         SH_RRX: result = {carry_in, value[31:1]};
      endcase
   end

endmodule : operand_shifter

`default_nettype wire

// ---- hw/subtract_instruction_decode.sv ----
// Decode and single-cycle execution of the subtract instruction family
`include "sub_decode_map.svh"
`default_nettype none

module subtract_instruction_decode
   import sub_decode_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_half_first,
   input  wire logic [15:0] instr_half_second,
   input  wire logic        cond_passed,
   input  wire logic        in_conditional_block,
   output logic [3:0]       read_addr_a,
   output logic [3:0]       read_addr_b,
   input  wire logic [31:0] read_data_a,
   input  wire logic [31:0] read_data_b,
   output logic             write_en,
   output logic [3:0]       write_addr,
   output logic [31:0]      write_data,
   output logic [3:0]       application_status_flags,
   output logic             exec_done,
   output logic             unpredictable,
   output logic             redirect_compare
);

   // ======================================================================
   // Field extraction
   logic        wide;
   logic [3:0]  first_source_field;
   logic [3:0]  second_source_field;
   logic [3:0]  dest_field;
   logic        flag_bit;
   logic [2:0]  const_mid_bits;
   logic [1:0]  shift_low_bits;
   logic [1:0]  shift_type_bits;
   logic [7:0]  const_low_byte;
   logic [6:0]  stack_const_field;
   logic [11:0] split_const;
   logic [4:0]  shift_amount_field;

   // A 32-bit word opens with 111 and anything but 00 in the next two bits
   assign wide                = (instr_half_first[15:13] == 3'h7) &&
                                (instr_half_first[12:11] != 2'h0);
   assign first_source_field  = instr_half_first[3:0];
   assign flag_bit            = instr_half_first[4];
   assign second_source_field = instr_half_second[3:0];
   assign dest_field          = instr_half_second[11:8];
   assign const_mid_bits      = instr_half_second[14:12];
   assign shift_low_bits      = instr_half_second[7:6];
   assign shift_type_bits     = instr_half_second[5:4];
   assign const_low_byte      = instr_half_second[7:0];
   assign stack_const_field   = instr_half_first[6:0];
   assign split_const         = {instr_half_first[10], const_mid_bits, const_low_byte};
   assign shift_amount_field  = {const_mid_bits, shift_low_bits};

   // ======================================================================
   // Pattern match for every encoding handled here
   logic hit16_reg;
   logic hit16_const_mid_bits;
   logic hit16_sp;
   logic hit32_reg;
   logic hit32_imm;
   logic hit32_immw;

   assign hit16_reg  = !wide && (instr_half_first[15:9] == `OP16_SUB_REG);
   assign hit16_const_mid_bits = !wide && (instr_half_first[15:9] == `OP16_SUB_CONST_MID_BITS);
   assign hit16_sp   = !wide && (instr_half_first[15:7] == `OP16_SP_IMM);
   assign hit32_reg  = wide && (instr_half_first[15:5] == `OP32_REG);
   assign hit32_imm  = wide && (instr_half_first[15:11] == `OP32_PREFIX) &&
                       (instr_half_first[9:5] == `OP32_IMM_MID) && !instr_half_second[15];
   assign hit32_immw = wide && (instr_half_first[15:11] == `OP32_PREFIX) &&
                       (instr_half_first[9:4] == `OP32_IMMW_MID) && !instr_half_second[15] &&
                       (first_source_field != `REG_PC);

   // ======================================================================
   // Modified constant expansion
   // Zero byte with a replicate pattern is left as produced; software must avoid it
   function automatic logic [31:0] modified_constant_expand(input logic [11:0] c);
      logic [31:0] base;
      logic [63:0] spun;
      base = {24'h000000, 1'b1, c[6:0]};
      spun = {base, base} >> c[11:7];
      if (c[11:10] == 2'h0) begin
         unique case (c[9:8])
            2'h0: modified_constant_expand = {24'h000000, c[7:0]};
            2'h1: modified_constant_expand = {8'h00, c[7:0], 8'h00, c[7:0]};
            2'h2: modified_constant_expand = {c[7:0], 8'h00, c[7:0], 8'h00};
            2'h3: modified_constant_expand = {c[7:0], c[7:0], c[7:0], c[7:0]};
         endcase
      end else begin
         modified_constant_expand = spun[31:0];
      end
   endfunction : modified_constant_expand

   // ======================================================================
   // Decode
   op_kind_type    kind;
   shift_kind_type sh_kind;
   logic [5:0]     sh_amount;
   logic [3:0]     n_idx;
   logic [3:0]     m_idx;
   logic [3:0]     d_idx;
   logic           setflags;
   logic           bad;
   logic           to_compare;
   logic [31:0]    imm32;

   always_comb begin
      kind       = OP_NONE;
      sh_kind    = SH_LSL;
      sh_amount  = 6'h00;
      n_idx      = 4'h0;
      m_idx      = 4'h0;
      d_idx      = 4'h0;
      setflags   = 1'b0;
      bad        = 1'b0;
      to_compare = 1'b0;
      imm32      = 32'h00000000;
      // Shift field decode shared by both 32-bit register forms
      unique case (shift_type_bits)
         2'h0: begin
            sh_kind   = SH_LSL;
            sh_amount = {1'b0, shift_amount_field};
         end
         2'h1: begin
            sh_kind   = SH_LSR;
            sh_amount = (shift_amount_field == 5'h00) ? 6'h20 : {1'b0, shift_amount_field};
         end
         2'h2: begin
            sh_kind   = SH_ASR;
            sh_amount = (shift_amount_field == 5'h00) ? 6'h20 : {1'b0, shift_amount_field};
         end
         2'h3: begin
            sh_kind   = (shift_amount_field == 5'h00) ? SH_RRX : SH_ROR;
            sh_amount = (shift_amount_field == 5'h00) ? 6'h01 : {1'b0, shift_amount_field};
         end
      endcase
      if (hit16_reg) begin
         kind      = OP_REG_REG;
         m_idx     = {1'b0, instr_half_first[8:6]};
         n_idx     = {1'b0, instr_half_first[5:3]};
         d_idx     = {1'b0, instr_half_first[2:0]};
         setflags  = !in_conditional_block;
         sh_kind   = SH_LSL;
         sh_amount = 6'h00;
      end else if (hit16_const_mid_bits) begin
         kind     = OP_REG_IMM;
         n_idx    = {1'b0, instr_half_first[5:3]};
         d_idx    = {1'b0, instr_half_first[2:0]};
         setflags = !in_conditional_block;
         imm32    = {29'h00000000, instr_half_first[8:6]};
      end else if (hit16_sp) begin
         kind  = OP_SP_IMM;
         n_idx = `REG_SP;
         d_idx = `REG_SP;
         imm32 = {23'h000000, stack_const_field, 2'h0};
      end else if (hit32_reg) begin
         m_idx    = second_source_field;
         n_idx    = first_source_field;
         d_idx    = dest_field;
         setflags = flag_bit;
         if (dest_field == `REG_PC && flag_bit) begin
            to_compare = 1'b1;
         end else if (first_source_field == `REG_SP) begin
            kind = OP_SP_REG;
            bad  = (d_idx == `REG_PC) || (m_idx == `REG_SP) || (m_idx == `REG_PC);
            // only small left shifts into SP
            if (d_idx == `REG_SP && (sh_kind != SH_LSL || sh_amount > `SP_SHIFT_MAX)) begin
               bad = 1'b1;
            end
         end else begin
            kind = OP_REG_REG;
            bad  = (d_idx == `REG_SP) || (d_idx == `REG_PC && !flag_bit) ||
                   (n_idx == `REG_PC) || (m_idx == `REG_SP) || (m_idx == `REG_PC);
         end
      end else if (hit32_imm) begin
         n_idx    = first_source_field;
         d_idx    = dest_field;
         setflags = flag_bit;
         imm32    = modified_constant_expand(split_const);
         if (dest_field == `REG_PC && flag_bit) begin
            to_compare = 1'b1;
         end else if (first_source_field == `REG_SP) begin
            kind = OP_SP_IMM;
            bad  = (d_idx == `REG_PC) && !flag_bit;
         end else begin
            kind = OP_REG_IMM;
            bad  = (d_idx == `REG_SP) || (d_idx == `REG_PC && !flag_bit) || (n_idx == `REG_PC);
         end
      end else if (hit32_immw) begin
         n_idx = first_source_field;
         d_idx = dest_field;
         imm32 = {20'h00000, split_const};
         if (first_source_field == `REG_SP) begin
            kind = OP_SP_IMM;
            bad  = (d_idx == `REG_PC);
         end else begin
            kind = OP_REG_IMM;
            bad  = (d_idx == `REG_SP) || (d_idx == `REG_PC);
         end
      end
   end

   // Register file read ports follow the decode in the same cycle
   assign read_addr_a = n_idx;
   assign read_addr_b = m_idx;

   // ======================================================================
   // Operand formation and carry_adder
   logic [3:0]  flags_q;
   logic [3:0]  flags_d;
   logic [31:0] shifted;
   logic [31:0] operand_b;
   logic [32:0] sum;
   logic [31:0] result;
   logic        carry_out;
   logic        overflow;

   // shift second operand with current carry
   operand_shifter u_operand_shifter (
      .value    (read_data_b),
      .kind     (sh_kind),
      .amount   (sh_amount),
      .carry_in (flags_q[`FLAG_C]),
      .result   (shifted)
   );

   // constant path inverted into the adder
   // register path inverted into the adder
   // SP minus constant uses the same adder
   // SP minus register uses the same adder
   // Read port A already carries SP for the SP forms, so one adder serves all
   always_comb begin
      operand_b = ((kind == OP_REG_REG) || (kind == OP_SP_REG)) ? shifted : imm32;
      sum       = {1'b0, read_data_a} + {1'b0, ~operand_b} + 33'h000000001;
      result    = sum[31:0];
      carry_out = sum[32];
      overflow  = (read_data_a[31] == ~operand_b[31]) && (result[31] != read_data_a[31]);
   end

   // ======================================================================
   // Result and flag state
   logic        write_en_q;
   logic        write_en_d;
   logic [3:0]  write_addr_q;
   logic [3:0]  write_addr_d;
   logic [31:0] write_data_q;
   logic [31:0] write_data_d;
   logic        done_q;
   logic        done_d;
   logic        unpred_q;
   logic        unpred_d;
   logic        cmp_q;
   logic        cmp_d;
   logic        commit;

   // Unpredictable words are reported and suppressed rather than executed
   always_comb begin
      commit       = instr_valid && cond_passed && (kind != OP_NONE) && !bad;
      done_d       = instr_valid && ((kind != OP_NONE) || to_compare);
      unpred_d     = instr_valid && cond_passed && (kind != OP_NONE) && bad;
      cmp_d        = instr_valid && to_compare;
      write_en_d   = commit;
      write_addr_d = commit ? d_idx : write_addr_q;
      write_data_d = commit ? result : write_data_q;
      flags_d      = flags_q;
      if (commit && setflags) begin
         flags_d[`FLAG_N] = result[`SIGN_BIT];
         flags_d[`FLAG_Z] = (result == 32'h00000000);
         flags_d[`FLAG_C] = carry_out;
         flags_d[`FLAG_V] = overflow;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         write_en_q   <= 1'b0;
         write_addr_q <= 4'h0;
         write_data_q <= 32'h00000000;
         flags_q      <= `FLAGS_RESET;
         done_q       <= 1'b0;
         unpred_q     <= 1'b0;
         cmp_q        <= 1'b0;
      end else begin
         write_en_q   <= write_en_d;
         write_addr_q <= write_addr_d;
         write_data_q <= write_data_d;
         flags_q      <= flags_d;
         done_q       <= done_d;
         unpred_q     <= unpred_d;
         cmp_q        <= cmp_d;
      end
   end

   assign write_en                 = write_en_q;
   assign write_addr               = write_addr_q;
   assign write_data               = write_data_q;
   assign application_status_flags = flags_q;
   assign exec_done                = done_q;
   assign unpredictable            = unpred_q;
   assign redirect_compare         = cmp_q;

endmodule : subtract_instruction_decode

`default_nettype wire

// ---- test/subtract_instruction_decode_monitor.sv ----
// Port-level checker for the subtract decoder
`default_nettype none

module subtract_instruction_decode_monitor (
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic        instr_valid,
   input wire logic [15:0] instr_half_first,
   input wire logic [15:0] instr_half_second,
   input wire logic        cond_passed,
   input wire logic        in_conditional_block,
   input wire logic [3:0]  read_addr_a,
   input wire logic [3:0]  read_addr_b,
   input wire logic [31:0] read_data_a,
   input wire logic [31:0] read_data_b,
   input wire logic        write_en,
   input wire logic [3:0]  write_addr,
   input wire logic [31:0] write_data,
   input wire logic [3:0]  application_status_flags,
   input wire logic        exec_done,
   input wire logic        unpredictable,
   input wire logic        redirect_compare
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========
   // Field taps, so slices can go through $past
   wire       nsub = instr_valid && (instr_half_first[15:9] == 7'h0d);
   wire       nsp  = instr_valid && cond_passed && (instr_half_first[15:7] == 9'h161);
   wire [2:0] ndst = instr_half_first[2:0];
   wire [6:0] spk  = instr_half_first[6:0];
   wire [3:0] flg  = application_status_flags;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   // ==========
   // Assertions
   a_narrow_read_addr: assert property (nsub |->
      read_addr_a == {1'b0, instr_half_first[5:3]} &&
      read_addr_b == {1'b0, instr_half_first[8:6]})
      else $error("narrow subtract read ports wrong");
   a_narrow_result: assert property (nsub && cond_passed |=> write_en && exec_done &&
      write_addr == {1'b0, $past(ndst)} && write_data == $past(read_data_a) - $past(read_data_b))
      else $error("narrow subtract result wrong");
   a_block_keeps_flags: assert property (nsub && cond_passed && in_conditional_block
      |=> flg == $past(flg)) else $error("flags changed inside block");
   a_sp_const_form: assert property (nsp |-> read_addr_a == 4'hd ##1
      (write_addr == 4'hd && flg == $past(flg) &&
       write_data == $past(read_data_a) - {$past(spk), 2'b00}))
      else $error("stack constant form wrong");
   a_fail_no_effect: assert property (instr_valid && !cond_passed |=>
      !write_en && !unpredictable && flg == $past(flg)) else $error("failed condition had effect");
   a_unpred_quiet: assert property (unpredictable |->
      exec_done && !write_en && flg == $past(flg)) else $error("illegal word had effect");
   a_compare_quiet: assert property (redirect_compare |->
      !write_en && !unpredictable && flg == $past(flg)) else $error("compare redirect wrote");
   a_zero_neg_flags: assert property (write_en && flg != $past(flg) |->
      flg[2] == (write_data == 32'h0) && flg[3] == write_data[31]) else $error("N or Z wrong");
   a_write_has_cause: assert property (write_en |->
      exec_done && $past(instr_valid) && $past(cond_passed)) else $error("write without cause");

   // Main scenarios reached
   c_write: cover property (write_en);
   c_unpred: cover property (unpredictable);
   c_compare: cover property (redirect_compare);
   c_skip: cover property (exec_done && !write_en && !unpredictable && !redirect_compare);
endmodule : subtract_instruction_decode_monitor

bind subtract_instruction_decode
   subtract_instruction_decode_monitor u_subtract_instruction_decode_monitor (
   .clk_sys, .nrst, .instr_valid, .instr_half_first, .instr_half_second, .cond_passed,
   .in_conditional_block, .read_addr_a, .read_addr_b, .read_data_a, .read_data_b, .write_en,
   .write_addr, .write_data, .application_status_flags, .exec_done, .unpredictable,
   .redirect_compare
);

`default_nettype wire

// ---- test/subtract_instruction_decode_bench.sv ----
// Self-checking bench for the subtract decoder
`default_nettype none

module subtract_instruction_decode_bench;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========
   // Signals
   logic        clk_sys, nrst, instr_valid, cond_passed, in_conditional_block;
   logic [15:0] instr_half_first, instr_half_second;
   logic [3:0]  read_addr_a, read_addr_b, write_addr, application_status_flags, flg;
   logic [31:0] read_data_a, read_data_b, write_data;
   logic        write_en, exec_done, unpredictable, redirect_compare;
   logic [31:0] regs [16];
   logic [35:0] sub_exp;
   int          n_errors = 0;
   int          num_checks = 0;

   // Combinational register file read, as the decoder expects
   assign read_data_a = regs[read_addr_a];
   assign read_data_b = regs[read_addr_b];

   subtract_instruction_decode u_subtract_instruction_decode (
      .clk_sys, .nrst, .instr_valid, .instr_half_first, .instr_half_second, .cond_passed,
      .in_conditional_block, .read_addr_a, .read_addr_b, .read_data_a, .read_data_b,
      .write_en, .write_addr, .write_data, .application_status_flags, .exec_done,
      .unpredictable, .redirect_compare
   );

   // ==========
   // Helpers
   function automatic logic [35:0] sub_ref(input logic [31:0] a, input logic [31:0] b);
      logic [32:0] s;
      s = {1'b0, a} + {1'b0, ~b} + 33'h1;
      return {s[31], s[31:0] == 32'h0, s[32], (a[31] != b[31]) && (s[31] != a[31]), s[31:0]};
   endfunction : sub_ref

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Word held valid one edge; valid stays up so words run back to back
   task automatic issue(input logic [15:0] f, input logic [15:0] s, input logic c, input logic b);
      instr_half_first = f;
      instr_half_second = s;
      cond_passed = c;
      in_conditional_block = b;
      instr_valid = 1'b1;
      @(negedge clk_sys);
   endtask : issue

   task automatic exp_out(input logic we, input logic [3:0] d, input logic [31:0] v,
                          input logic unp, input logic rd);
      chk("exec_done", 32'h1, {31'h0, exec_done});
      chk("write_en", {31'h0, we}, {31'h0, write_en});
      chk("unpredictable", {31'h0, unp}, {31'h0, unpredictable});
      chk("redirect_compare", {31'h0, rd}, {31'h0, redirect_compare});
      chk("flags", {28'h0, flg}, {28'h0, application_status_flags});
      if (we) begin
         chk("write_addr", {28'h0, d}, {28'h0, write_addr});
         chk("write_data", v, write_data);
      end
   endtask : exp_out

   task automatic sub_go(input logic [15:0] f, input logic [15:0] s, input logic b,
                         input logic [31:0] x, input logic [31:0] y, input logic sf,
                         input logic [3:0] d);
      sub_exp = sub_ref(x, y);
      if (sf) begin
         flg = sub_exp[35:32];
      end
      issue(f, s, 1'b1, b);
      exp_out(1'b1, d, sub_exp[31:0], 1'b0, 1'b0);
   endtask : sub_go

   task automatic bad_go(input logic [31:0] w);
      issue(w[31:16], w[15:0], 1'b1, 1'b0);
      exp_out(1'b0, 4'h0, 32'h0, 1'b1, 1'b0);
   endtask : bad_go

   // ==========
   // Scenarios
   task automatic t_narrow();
      regs[1] = 32'h5;
      regs[2] = 32'h5;
      sub_go(16'h1a8a, 16'h0, 1'b0, regs[1], regs[2], 1'b1, 4'h2);
      regs[1] = 32'h1;
      sub_go(16'h1a8a, 16'h0, 1'b1, regs[1], regs[2], 1'b0, 4'h2);
      regs[3] = 32'h3;
      sub_go(16'h1fdc, 16'h0, 1'b0, regs[3], 32'h7, 1'b1, 4'h4);
   endtask : t_narrow

   // Second word takes the carry left by the first
   task automatic t_wide_reg();
      regs[1] = 32'h100;
      regs[2] = 32'h10;
      sub_go(16'hebb1, 16'h1402, 1'b0, regs[1], regs[2] << 4, 1'b1, 4'h4);
      sub_go(16'hebb1, 16'h0432, 1'b0, regs[1], {flg[1], regs[2][31:1]}, 1'b1, 4'h4);
      sub_go(16'heba1, 16'h0402, 1'b0, regs[1], regs[2], 1'b0, 4'h4);
      // Arithmetic shift by 32 and logical shift right on a negative operand
      regs[2] = 32'h80000010;
      sub_go(16'hebb1, 16'h0422, 1'b0, regs[1], 32'hffffffff, 1'b1, 4'h4);
      sub_go(16'hebb1, 16'h1412, 1'b0, regs[1], 32'h08000001, 1'b1, 4'h4);
   endtask : t_wide_reg

   // General constant forms: replicate patterns, plain wide constant, compare
   task automatic t_reg_const();
      sub_go(16'hf1b1, 16'h3401, 1'b0, regs[1], 32'h01010101, 1'b1, 4'h4);
      sub_go(16'hf1a1, 16'h2402, 1'b0, regs[1], 32'h02000200, 1'b0, 4'h4);
      sub_go(16'hf2a1, 16'h0410, 1'b0, regs[1], 32'h00000010, 1'b0, 4'h4);
      issue(16'hf1b1, 16'h0f01, 1'b1, 1'b0);
      exp_out(1'b0, 4'h0, 32'h0, 1'b0, 1'b1);
   endtask : t_reg_const

   task automatic t_illegal();
      logic [31:0] tbl [5] = '{32'hebb10d02, 32'heba10f02, 32'hebbf0402,
                               32'hebb1040d, 32'hebb1040f};
      issue(16'hebb1, 16'h0f02, 1'b1, 1'b0);
      exp_out(1'b0, 4'h0, 32'h0, 1'b0, 1'b1);
      for (int i = 0; i < 5; i++) begin
         bad_go(tbl[i]);
      end
      issue(16'hebb1, 16'h0d02, 1'b0, 1'b0);
      exp_out(1'b0, 4'h0, 32'h0, 1'b0, 1'b0);
      issue(16'h0000, 16'h0, 1'b1, 1'b0);
      chk("exec_done", 32'h0, {31'h0, exec_done});
   endtask : t_illegal

   task automatic t_sp_const();
      regs[13] = 32'h1000;
      sub_go(16'hb0ff, 16'h0, 1'b0, regs[13], 32'h1fc, 1'b0, 4'hd);
      sub_go(16'hf6ad, 16'h74ff, 1'b0, regs[13], 32'hfff, 1'b0, 4'h4);
      sub_go(16'hf1bd, 16'h14ab, 1'b0, regs[13], 32'h00ab00ab, 1'b1, 4'h4);
      sub_go(16'hf1bd, 16'h4400, 1'b0, regs[13], 32'h80000000, 1'b1, 4'h4);
      bad_go(32'hf6ad7fff);
      bad_go(32'hf1ad0f00);
   endtask : t_sp_const

   task automatic t_sp_reg();
      logic [15:0] tbl [5] = '{16'h1d02, 16'h0d52, 16'h0f02, 16'h040d, 16'h040f};
      regs[2] = 32'h12345678;
      sub_go(16'hebbd, 16'h2432, 1'b0, regs[13], 32'h78123456, 1'b1, 4'h4);
      sub_go(16'hebad, 16'h0dc2, 1'b0, regs[13], regs[2] << 3, 1'b0, 4'hd);
      for (int i = 0; i < 5; i++) begin
         bad_go({16'hebad, tbl[i]});
      end
   endtask : t_sp_reg

   task automatic close_out();
      if (n_errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   // ==========
   // Clock, watchdog and main sequence
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Whole run is under a hundred cycles, so this only cuts a hang
   initial begin
      repeat (2000) @(posedge clk_sys);
      n_errors++;
      close_out();
   end

   initial begin
      nrst = 1'b0;
      instr_valid = 1'b0;
      instr_half_first = 16'h0;
      instr_half_second = 16'h0;
      cond_passed = 1'b0;
      in_conditional_block = 1'b0;
      flg = 4'h0;
      for (int i = 0; i < 16; i++) begin
         regs[i] = 32'h0;
      end
      repeat (3) @(negedge clk_sys);
      nrst = 1'b1;
      t_narrow();
      t_wide_reg();
      t_reg_const();
      t_illegal();
      t_sp_const();
      t_sp_reg();
      close_out();
   end
endmodule : subtract_instruction_decode_bench

`default_nettype wire
